// ===== rtl/gpp_consts.svh
// register offsets, reset values and field positions for the two-port gpio block
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
`define GPP_OFS_P6_LATCH 12'h000
`define GPP_OFS_P6_DIR 12'h004
`define GPP_OFS_P6_PULL 12'h008
`define GPP_OFS_P7_LATCH 12'h00c
`define GPP_OFS_P7_DIR 12'h010
`define GPP_OFS_P7_PULL 12'h014
`define GPP_OFS_CTRL 12'h018
`define GPP_OFS_P6_RMW 12'h01c
`define GPP_OFS_P7_RMW 12'h020
`define GPP_DIR_RST 8'h00
`define GPP_LATCH_RST 8'h00
`define GPP_PULL_RST 8'h00
`define GPP_CTRL_FLOAT_BIT 0
`define GPP_CTRL_SCK_WAKE_BIT 1
`define GPP_CTRL_SIN_WAKE_BIT 2
`define GPP_P6_SCK_PIN 5
`define GPP_P6_SIN_PIN 7
`endif

// ===== rtl/gpp_pkg.sv
// shared types for the two-port gpio block
package gpp_pkg;
  // register select decoded from the bus address
  typedef enum logic [9:0] {
    GPP_SEL_NONE = 10'h001,
    GPP_SEL_P6_LATCH = 10'h002,
    GPP_SEL_P6_DIR = 10'h004,
    GPP_SEL_P6_PULL = 10'h008,
    GPP_SEL_P7_LATCH = 10'h010,
    GPP_SEL_P7_DIR = 10'h020,
    GPP_SEL_P7_PULL = 10'h040,
    GPP_SEL_CTRL = 10'h080,
    GPP_SEL_P6_RMW = 10'h100,
    GPP_SEL_P7_RMW = 10'h200
  } gpp_sel_t;
endpackage

// ===== rtl/gpp_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module gpp_sync #(
  parameter int WIDTH = 8
) (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by the second
  // two stages; reset value low matches the blocked input level
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else if (i_clk_en) begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/gpp_pin_mux.sv
// per-pin output mux, enable, pull-up and standby input gating for one port
`timescale 1ns/10ps
`default_nettype none
module gpp_pin_mux #(
  parameter int WIDTH = 8
) (
  // port registers
  input wire logic [WIDTH-1:0] i_latch,
  input wire logic [WIDTH-1:0] i_dir,
  input wire logic [WIDTH-1:0] i_pull,
  // peripheral outputs
  input wire logic [WIDTH-1:0] i_per_oe,
  input wire logic [WIDTH-1:0] i_per_out,
  // standby
  input wire logic i_float,
  input wire logic [WIDTH-1:0] i_keep_in,
  input wire logic [WIDTH-1:0] i_pin_in,
  // results
  output logic [WIDTH-1:0] o_pin_out,
  output logic [WIDTH-1:0] o_pin_oe,
  output logic [WIDTH-1:0] o_pull_on,
  output logic [WIDTH-1:0] o_pin_gated
);
  // refused at elaboration: the slices are sized for one to eight pins
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("gpp_pin_mux width out of range");
  end
  genvar g;
  // one identical slice per pin; continuous assigns keep each bit to one driver
  for (g = 0; g < WIDTH; g++) begin : g_pin
    // peripheral owns the pin when its enable is set
    assign o_pin_out[g] = i_per_oe[g] ? i_per_out[g] : i_latch[g];
    // driven by a peripheral or by a port in output mode, unless floated
    assign o_pin_oe[g] = !i_float && (i_per_oe[g] || i_dir[g]);
    // pull-up cut while the pin drives low
    assign o_pull_on[g] = i_pull[g] && !(o_pin_oe[g] && !o_pin_out[g]);
    // blocked input reads low in floating standby
    assign o_pin_gated[g] = (i_float && !i_keep_in[g]) ? 1'b0 : i_pin_in[g];
  end
endmodule
`default_nettype wire

// ===== rtl/gpp_top.sv
// gpio logic for the eight-pin port 6 and three-pin port 7 with an apb register slave
//
// Functional notes
// - direction one makes pin an output
// - direction zero makes pin an input
// - output pin drives its latch bit
// - data writes always update latch
// - read gives latch or pin level
// - rmw read returns latch contents
// - peripheral enable routes peripheral to pin
// - peripheral-driven pin reads actual level
// - peripheral inputs read as pin level
// - reset clears all direction bits
// - float bit in standby tristates pins
// - floated pin input held low
// - serial clock and rx stay open; here only while their wake bits in the control register are set
// - float bit zero holds pin states
// - pull-up enable connects pull-up
// - driving low disconnects pull-up
// - port 6 bit n controls pin n
// - port 7 implements bits zero to two
// - port 6 pins 0-4 timer sharing
// - port 6 pins 5-7 serial sharing
// - port 7 pins reload timer sharing
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_top #(
  parameter int P6_WIDTH = 8,
  parameter int P7_WIDTH = 3
) (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // standby request from the standby controller (stop or watch mode)
  input wire logic i_standby,
  // port 6 pins
  input wire logic [7:0] i_p6_pin_in,
  output logic [7:0] o_p6_pin_out,
  output logic [7:0] o_p6_pin_oe,
  output logic [7:0] o_p6_pull_on,
  // port 7 pins
  input wire logic [2:0] i_p7_pin_in,
  output logic [2:0] o_p7_pin_out,
  output logic [2:0] o_p7_pin_oe,
  output logic [2:0] o_p7_pull_on,
  // peripheral outputs and their enables, same clock
  input wire logic i_pulse_gen1_out_a,
  input wire logic i_pulse_gen1_out_a_oe,
  input wire logic i_pulse_gen1_out_b,
  input wire logic i_pulse_gen1_out_b_oe,
  input wire logic i_composite_timer1_out_a,
  input wire logic i_composite_timer1_out_a_oe,
  input wire logic i_composite_timer1_out_b,
  input wire logic i_composite_timer1_out_b_oe,
  input wire logic i_serial_clk_out,
  input wire logic i_serial_clk_oe,
  input wire logic i_serial_tx_out,
  input wire logic i_serial_tx_oe,
  input wire logic i_reload_timer0_out,
  input wire logic i_reload_timer0_out_oe,
  // peripheral inputs, synchronised and standby-gated
  output logic o_composite_timer1_ext_clock,
  output logic o_serial_clk_in,
  output logic o_serial_rx_in,
  output logic o_reload_timer0_in
);
  // refused at elaboration: the sharing map and register layout fix these widths
  if (P6_WIDTH != 8) begin : g_bad_p6
    $error("port 6 must be eight pins wide");
  end
  if (P7_WIDTH != 3) begin : g_bad_p7
    $error("port 7 must be three pins wide");
  end

  // registers
  // latch and pull-up reset to zero so no pin sees an unknown value
  // before software has written them
  logic [7:0] p6_latch_r; // port6_output_latch
  logic [7:0] p6_dir_r; // port6_direction_bits
  logic [7:0] p6_pull_r; // port6_pullup_enables
  logic [2:0] p7_latch_r; // port7_output_latch
  logic [2:0] p7_dir_r; // port7_direction_bits
  logic [2:0] p7_pull_r; // port7_pullup_enables
  logic float_r; // standby_pin_float_bit
  logic sck_wake_r; // irq enable keeping serial clock input open
  logic sin_wake_r; // irq enable keeping serial rx input open

  // synchronised pins
  logic [7:0] p6_sync;
  logic [2:0] p7_sync;
  // combinational pin results
  logic [7:0] p6_out_c, p6_oe_c, p6_pull_c, p6_gated;
  logic [2:0] p7_out_c, p7_oe_c, p7_pull_c, p7_gated;
  logic [7:0] p6_per_oe, p6_per_out, p6_keep;
  logic [2:0] p7_per_oe, p7_per_out;
  logic float_now; // pins floated this cycle
  logic [7:0] p6_read, p7_read;
  gpp_pkg::gpp_sel_t sel;
  logic wr_en, rd_en;
  logic [31:0] rdata_nxt;

  // pins come from outside the clock domain
  // two flops cost two cycles of read latency but keep metastability out
  gpp_sync #(.WIDTH(8)) u_sync6 (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(i_p6_pin_in),
    .o_sync(p6_sync)
  );
  gpp_sync #(.WIDTH(3)) u_sync7 (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(i_p7_pin_in),
    .o_sync(p7_sync)
  );

  // peripheral sharing map for port 6
  // input-only pins 4 and 7 have no output enable and carry zero here
  always_comb begin
    p6_per_oe = {1'b0, i_serial_tx_oe, i_serial_clk_oe, 1'b0,
                 i_composite_timer1_out_b_oe, i_composite_timer1_out_a_oe,
                 i_pulse_gen1_out_b_oe, i_pulse_gen1_out_a_oe};
    p6_per_out = {1'b0, i_serial_tx_out, i_serial_clk_out, 1'b0,
                  i_composite_timer1_out_b, i_composite_timer1_out_a,
                  i_pulse_gen1_out_b, i_pulse_gen1_out_a};
    // pin 2 of port 7 has no peripheral
    p7_per_oe = {2'b00, i_reload_timer0_out_oe};
    p7_per_out = {2'b00, i_reload_timer0_out};
  end

  // float only while standby and the float bit are both set
  // the two serial inputs may stay open so an edge on them can wake the device
  always_comb begin
    float_now = float_r && i_standby;
    p6_keep = 8'h00;
    p6_keep[`GPP_P6_SCK_PIN] = sck_wake_r;
    p6_keep[`GPP_P6_SIN_PIN] = sin_wake_r;
  end

  gpp_pin_mux #(.WIDTH(8)) u_mux6 (
    .i_latch(p6_latch_r),
    .i_dir(p6_dir_r),
    .i_pull(p6_pull_r),
    .i_per_oe(p6_per_oe),
    .i_per_out(p6_per_out),
    .i_float(float_now),
    .i_keep_in(p6_keep),
    .i_pin_in(p6_sync),
    .o_pin_out(p6_out_c),
    .o_pin_oe(p6_oe_c),
    .o_pull_on(p6_pull_c),
    .o_pin_gated(p6_gated)
  );
  gpp_pin_mux #(.WIDTH(3)) u_mux7 (
    .i_latch(p7_latch_r),
    .i_dir(p7_dir_r),
    .i_pull(p7_pull_r),
    .i_per_oe(p7_per_oe),
    .i_per_out(p7_per_out),
    .i_float(float_now),
    .i_keep_in(3'b000),
    .i_pin_in(p7_sync),
    .o_pin_out(p7_out_c),
    .o_pin_oe(p7_oe_c),
    .o_pull_on(p7_pull_c),
    .o_pin_gated(p7_gated)
  );

  // address decode; unmapped addresses get a slave error
  // the full address is compared, so aliases of a register are refused too
  always_comb begin
    case (i_paddr)
      `GPP_OFS_P6_LATCH: sel = gpp_pkg::GPP_SEL_P6_LATCH;
      `GPP_OFS_P6_DIR: sel = gpp_pkg::GPP_SEL_P6_DIR;
      `GPP_OFS_P6_PULL: sel = gpp_pkg::GPP_SEL_P6_PULL;
      `GPP_OFS_P7_LATCH: sel = gpp_pkg::GPP_SEL_P7_LATCH;
      `GPP_OFS_P7_DIR: sel = gpp_pkg::GPP_SEL_P7_DIR;
      `GPP_OFS_P7_PULL: sel = gpp_pkg::GPP_SEL_P7_PULL;
      `GPP_OFS_CTRL: sel = gpp_pkg::GPP_SEL_CTRL;
      `GPP_OFS_P6_RMW: sel = gpp_pkg::GPP_SEL_P6_RMW;
      `GPP_OFS_P7_RMW: sel = gpp_pkg::GPP_SEL_P7_RMW;
      default: sel = gpp_pkg::GPP_SEL_NONE;
    endcase
  end

  // access phase while no answer is pending; answer comes one cycle later
  // a write needs the low byte lane; the other lanes carry no register bits
  assign wr_en = i_psel && i_penable && i_pwrite && !o_pready && i_pstrb[0];
  assign rd_en = i_psel && i_penable && !i_pwrite && !o_pready;

  // ordinary read: latch for port outputs, synchronised pin level otherwise
  // the pin level lags the pin by the two synchroniser flops
  always_comb begin
    p6_read = 8'h00;
    p7_read = 8'h00;
    for (int k = 0; k < 8; k++) begin
      // peripheral-driven or input pin shows the pin level
      p6_read[k] = (p6_dir_r[k] && !p6_per_oe[k]) ? p6_latch_r[k] : p6_gated[k];
    end
    for (int k = 0; k < 3; k++) begin
      p7_read[k] = (p7_dir_r[k] && !p7_per_oe[k]) ? p7_latch_r[k] : p7_gated[k];
    end
  end

  // read data mux; upper bits always zero
  // port 7 bits 7..3 do not exist and read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (sel)
      gpp_pkg::GPP_SEL_P6_LATCH: rdata_nxt[7:0] = p6_read;
      gpp_pkg::GPP_SEL_P6_DIR: rdata_nxt[7:0] = p6_dir_r;
      gpp_pkg::GPP_SEL_P6_PULL: rdata_nxt[7:0] = p6_pull_r;
      gpp_pkg::GPP_SEL_P7_LATCH: rdata_nxt[7:0] = p7_read;
      gpp_pkg::GPP_SEL_P7_DIR: rdata_nxt[2:0] = p7_dir_r;
      gpp_pkg::GPP_SEL_P7_PULL: rdata_nxt[2:0] = p7_pull_r;
      gpp_pkg::GPP_SEL_CTRL: begin
        rdata_nxt[`GPP_CTRL_FLOAT_BIT] = float_r;
        rdata_nxt[`GPP_CTRL_SCK_WAKE_BIT] = sck_wake_r;
        rdata_nxt[`GPP_CTRL_SIN_WAKE_BIT] = sin_wake_r;
      end
      // read-modify-write view returns the latch itself
      gpp_pkg::GPP_SEL_P6_RMW: rdata_nxt[7:0] = p6_latch_r;
      gpp_pkg::GPP_SEL_P7_RMW: rdata_nxt[2:0] = p7_latch_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait state, pready pulses for one cycle
  // the !o_pready term stops a held access phase from being taken twice
  // read data is zero outside the answer cycle so stale values never leak
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_clk_en) begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && (sel == gpp_pkg::GPP_SEL_NONE);
      o_prdata <= rd_en ? rdata_nxt : 32'h0000_0000;
    end
  end

  // port 6 registers; writes to either latch view land in the latch
  // a slave-error write matches no select and changes nothing
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      p6_latch_r <= `GPP_LATCH_RST;
      p6_dir_r <= `GPP_DIR_RST;
      p6_pull_r <= `GPP_PULL_RST;
    end else if (i_clk_en && wr_en) begin
      if (sel == gpp_pkg::GPP_SEL_P6_LATCH || sel == gpp_pkg::GPP_SEL_P6_RMW) begin
        p6_latch_r <= i_pwdata[7:0];
      end
      if (sel == gpp_pkg::GPP_SEL_P6_DIR) begin
        p6_dir_r <= i_pwdata[7:0];
      end
      if (sel == gpp_pkg::GPP_SEL_P6_PULL) begin
        p6_pull_r <= i_pwdata[7:0];
      end
    end
  end

  // port 7 registers; only bits 2..0 exist
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      // reset constants are eight bits wide; cut to the three real bits
      p7_latch_r <= 3'(`GPP_LATCH_RST);
      p7_dir_r <= 3'(`GPP_DIR_RST);
      p7_pull_r <= 3'(`GPP_PULL_RST);
    end else if (i_clk_en && wr_en) begin
      if (sel == gpp_pkg::GPP_SEL_P7_LATCH || sel == gpp_pkg::GPP_SEL_P7_RMW) begin
        p7_latch_r <= i_pwdata[2:0];
      end
      if (sel == gpp_pkg::GPP_SEL_P7_DIR) begin
        p7_dir_r <= i_pwdata[2:0];
      end
      if (sel == gpp_pkg::GPP_SEL_P7_PULL) begin
        p7_pull_r <= i_pwdata[2:0];
      end
    end
  end

  // standby control bits
  // the float bit only takes effect while the standby input is high
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      float_r <= 1'b0;
      sck_wake_r <= 1'b0;
      sin_wake_r <= 1'b0;
    end else if (i_clk_en && wr_en && sel == gpp_pkg::GPP_SEL_CTRL) begin
      float_r <= i_pwdata[`GPP_CTRL_FLOAT_BIT];
      sck_wake_r <= i_pwdata[`GPP_CTRL_SCK_WAKE_BIT];
      sin_wake_r <= i_pwdata[`GPP_CTRL_SIN_WAKE_BIT];
    end
  end

  // registered pin drives; one cycle from register change to pin
  // registering hides decode glitches from the board at the cost of a cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_p6_pin_out <= 8'h00;
      o_p6_pin_oe <= 8'h00;
      o_p6_pull_on <= 8'h00;
      o_p7_pin_out <= 3'b000;
      o_p7_pin_oe <= 3'b000;
      o_p7_pull_on <= 3'b000;
    end else if (i_clk_en) begin
      o_p6_pin_out <= p6_out_c;
      o_p6_pin_oe <= p6_oe_c;
      o_p6_pull_on <= p6_pull_c;
      o_p7_pin_out <= p7_out_c;
      o_p7_pin_oe <= p7_oe_c;
      o_p7_pull_on <= p7_pull_c;
    end
  end

  // peripheral inputs read the gated pin level even in port mode
  // in floating standby these read low unless kept open for wake-up
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_composite_timer1_ext_clock <= 1'b0;
      o_serial_clk_in <= 1'b0;
      o_serial_rx_in <= 1'b0;
      o_reload_timer0_in <= 1'b0;
    end else if (i_clk_en) begin
      o_composite_timer1_ext_clock <= p6_gated[4];
      o_serial_clk_in <= p6_gated[`GPP_P6_SCK_PIN];
      o_serial_rx_in <= p6_gated[`GPP_P6_SIN_PIN];
      o_reload_timer0_in <= p7_gated[1];
    end
  end
endmodule
`default_nettype wire

// ===== tb/gpp_props.sv
// concurrent checks on the ports of the two-port gpio top
`timescale 1ns/10ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_props (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // apb answer side
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  // standby
  input wire logic i_standby,
  // pins
  input wire logic [7:0] o_p6_pin_out,
  input wire logic [7:0] o_p6_pin_oe,
  input wire logic [7:0] o_p6_pull_on,
  input wire logic [2:0] o_p7_pin_out,
  input wire logic [2:0] o_p7_pin_oe,
  input wire logic [2:0] o_p7_pull_on,
  // peripheral outputs
  input wire logic i_pulse_gen1_out_a,
  input wire logic i_pulse_gen1_out_a_oe,
  input wire logic i_composite_timer1_out_b,
  input wire logic i_composite_timer1_out_b_oe,
  input wire logic i_serial_tx_out,
  input wire logic i_serial_tx_oe,
  input wire logic i_reload_timer0_out,
  input wire logic i_reload_timer0_out_oe
);
  // single domain, so clock and reset are given once
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  // pins leave reset as inputs
  property p_rst_in;
    $fell(i_sys_rst) |-> (o_p6_pin_oe == 8'h00) && (o_p7_pin_oe == 3'h0);
  endproperty
  a_rst_in: assert property (p_rst_in)
    else $error("pin driven right after reset");
  // a pin driving low never has its pull-up on
  property p_p6_pull_low;
    (o_p6_pull_on & o_p6_pin_oe & ~o_p6_pin_out) == 8'h00;
  endproperty
  a_p6_pull_low: assert property (p_p6_pull_low)
    else $error("port 6 pull-up on a low output");
  property p_p7_pull_low;
    (o_p7_pull_on & o_p7_pin_oe & ~o_p7_pin_out) == 3'h0;
  endproperty
  a_p7_pull_low: assert property (p_p7_pull_low)
    else $error("port 7 pull-up on a low output");
  // enabled peripheral outputs reach their pins one edge later
  property p_pg_a;
    (i_pulse_gen1_out_a_oe && !i_standby) |=>
      o_p6_pin_oe[0] && (o_p6_pin_out[0] == $past(i_pulse_gen1_out_a));
  endproperty
  a_pg_a: assert property (p_pg_a)
    else $error("pin 0 not following pulse output");
  property p_ct_b;
    (i_composite_timer1_out_b_oe && !i_standby) ##1 1'b1 |->
      o_p6_pin_oe[3] && (o_p6_pin_out[3] == $past(i_composite_timer1_out_b));
  endproperty
  a_ct_b: assert property (p_ct_b)
    else $error("pin 3 not following timer output");
  property p_tx;
    (i_serial_tx_oe && !i_standby) |=> o_p6_pin_oe[6] && (o_p6_pin_out[6] == $past(i_serial_tx_out));
  endproperty
  a_tx: assert property (p_tx)
    else $error("pin 6 not following serial output");
  property p_rt;
    (i_reload_timer0_out_oe && !i_standby) |=>
      o_p7_pin_oe[0] && (o_p7_pin_out[0] == $past(i_reload_timer0_out));
  endproperty
  a_rt: assert property (p_rt)
    else $error("port 7 pin 0 not following reload output");
  // port 7 reads carry nothing above bit 2
  property p_p7_upper;
    (o_pready && !i_pwrite && (i_paddr inside {`GPP_OFS_P7_LATCH, `GPP_OFS_P7_DIR,
      `GPP_OFS_P7_PULL, `GPP_OFS_P7_RMW})) |-> (o_prdata[31:3] == 29'h0);
  endproperty
  a_p7_upper: assert property (p_p7_upper)
    else $error("port 7 read has upper bits set");
endmodule
`default_nettype wire

// ===== tb/gpp_board.sv
// board-side model of one port's pins: drivers, pull-ups and floating lines
`timescale 1ns/10ps
`default_nettype none
module gpp_board #(
  parameter int WIDTH = 8
) (
  // clock
  input wire logic i_ref_clk,
  // device side
  input wire logic [WIDTH-1:0] i_drv_oe,
  input wire logic [WIDTH-1:0] i_drv_val,
  input wire logic [WIDTH-1:0] i_pull,
  // board drivers
  input wire logic [WIDTH-1:0] i_ext_en,
  input wire logic [WIDTH-1:0] i_ext_val,
  // resolved level
  output logic [WIDTH-1:0] o_level
);
  // last level, inverted on a floating pin so no stale value survives
  logic [WIDTH-1:0] last_r = '0;
  // device drive first, then board drive, then pull-up, else wander
  always_comb begin
    for (int k = 0; k < WIDTH; k++) begin
      if (i_drv_oe[k]) o_level[k] = i_drv_val[k];
      else if (i_ext_en[k]) o_level[k] = i_ext_val[k];
      else if (i_pull[k]) o_level[k] = 1'b1;
      else o_level[k] = ~last_r[k];
    end
  end
  // remember the level for the floating case
  always @(posedge i_ref_clk) last_r <= o_level;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the two-port gpio block over apb
`timescale 1ns/10ps
`default_nettype none
`include "gpp_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  // clock, reset, bus
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1, clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, standby = 1'b0;
  logic [3:0] pstrb = 4'hf;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  // pins, board drivers, peripherals (0 pga 1 pgb 2 cta 3 ctb 4 sck 5 tx 6 rt)
  logic [7:0] ext6_val = 8'h00, ext6_en = 8'h00, p6_in, p6_out, p6_oe, p6_pull;
  logic [2:0] ext7_val = 3'h0, ext7_en = 3'h0, p7_in, p7_out, p7_oe, p7_pull;
  logic [6:0] per_out = 7'h00, per_oe = 7'h00;
  logic [3:0] per_in;
  int bad_count = 0, tests_run = 0, cycles = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  gpp_top uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_standby(standby), .i_p6_pin_in(p6_in), .o_p6_pin_out(p6_out),
    .o_p6_pin_oe(p6_oe), .o_p6_pull_on(p6_pull), .i_p7_pin_in(p7_in), .o_p7_pin_out(p7_out),
    .o_p7_pin_oe(p7_oe), .o_p7_pull_on(p7_pull),
    .i_pulse_gen1_out_a(per_out[0]), .i_pulse_gen1_out_a_oe(per_oe[0]),
    .i_pulse_gen1_out_b(per_out[1]), .i_pulse_gen1_out_b_oe(per_oe[1]),
    .i_composite_timer1_out_a(per_out[2]), .i_composite_timer1_out_a_oe(per_oe[2]),
    .i_composite_timer1_out_b(per_out[3]), .i_composite_timer1_out_b_oe(per_oe[3]),
    .i_serial_clk_out(per_out[4]), .i_serial_clk_oe(per_oe[4]),
    .i_serial_tx_out(per_out[5]), .i_serial_tx_oe(per_oe[5]),
    .i_reload_timer0_out(per_out[6]), .i_reload_timer0_out_oe(per_oe[6]),
    .o_composite_timer1_ext_clock(per_in[0]), .o_serial_clk_in(per_in[1]),
    .o_serial_rx_in(per_in[2]), .o_reload_timer0_in(per_in[3]));
  gpp_board #(.WIDTH(8)) u_b6 (.i_ref_clk(i_ref_clk), .i_drv_oe(p6_oe), .i_drv_val(p6_out),
    .i_pull(p6_pull), .i_ext_en(ext6_en), .i_ext_val(ext6_val), .o_level(p6_in));
  gpp_board #(.WIDTH(3)) u_b7 (.i_ref_clk(i_ref_clk), .i_drv_oe(p7_oe), .i_drv_val(p7_out),
    .i_pull(p7_pull), .i_ext_en(ext7_en), .i_ext_val(ext7_val), .o_level(p7_in));
  // one apb transfer, entered just after an edge; waits for pready, no fixed latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    @(posedge i_ref_clk);
    while (pready !== 1'b1) @(posedge i_ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, {24'h000000, e})
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // counts, verdict, end of run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, well above the roughly 150 cycles the tests need
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    idle(12);
    i_sys_rst <= 1'b0;
    idle(1);
    `CHK(p6_oe, 8'h00)
    rdc(`GPP_OFS_P6_DIR, 8'h00);
    rdc(`GPP_OFS_P7_DIR, 8'h00);
    $display("test reset done");
    wr(`GPP_OFS_P6_DIR, 8'hff);
    wr(`GPP_OFS_P6_LATCH, 8'ha5);
    idle(2);
    `CHK({p6_oe, p6_out}, 16'hffa5)
    rdc(`GPP_OFS_P6_LATCH, 8'ha5);
    wr(`GPP_OFS_P6_DIR, 8'h0f);
    ext6_val <= 8'h3c;
    ext6_en <= 8'hf0;
    idle(3);
    rdc(`GPP_OFS_P6_LATCH, 8'h35);
    rdc(`GPP_OFS_P6_RMW, 8'ha5);
    wr(`GPP_OFS_P6_LATCH, 8'h5a);
    wr(`GPP_OFS_P6_PULL, 8'hff);
    idle(2);
    `CHK({p6_oe, p6_out & 8'h0f, p6_pull}, 24'h0f0afa)
    rdc(`GPP_OFS_P6_RMW, 8'h5a);
    $display("test port done");
    ext6_en <= 8'h90;
    per_out <= 7'h55;
    per_oe <= 7'h7f;
    ext7_val <= 3'h2;
    ext7_en <= 3'h2;
    idle(3);
    `CHK({p6_oe & 8'h6f, p6_out & 8'h6f}, 16'h6f25)
    `CHK({p7_oe[0], p7_out[0]}, 2'b11)
    rdc(`GPP_OFS_P6_LATCH, 8'h35);
    rdc(`GPP_OFS_P6_RMW, 8'h5a);
    `CHK({per_in[3], per_in[1:0]}, 3'b111)
    per_oe <= 7'h00;
    ext7_en <= 3'h0;
    $display("test peripheral done");
    wr(`GPP_OFS_P7_DIR, 8'hff);
    rdc(`GPP_OFS_P7_DIR, 8'h07);
    wr(`GPP_OFS_P7_LATCH, 8'hff);
    rdc(`GPP_OFS_P7_RMW, 8'h07);
    wr(`GPP_OFS_P7_PULL, 8'hfd);
    rdc(`GPP_OFS_P7_PULL, 8'h05);
    `CHK({p7_oe, p7_out, p7_pull}, 9'h1fd)
    // a write without the low byte lane must leave the latch alone
    pstrb <= 4'h0;
    wr(`GPP_OFS_P7_LATCH, 8'h00);
    `CHK(err, 1'b0)
    pstrb <= 4'hf;
    rdc(`GPP_OFS_P7_RMW, 8'h07);
    wr(12'h040, 8'hff);
    `CHK(err, 1'b1)
    $display("test port7 done");
    wr(`GPP_OFS_CTRL, 8'h01);
    // a low clock enable freezes the pins, so the float waits for it
    clk_en <= 1'b0;
    standby <= 1'b1;
    idle(4);
    `CHK({p6_oe, p7_oe}, 11'h07f)
    clk_en <= 1'b1;
    idle(4);
    `CHK({p6_oe, p7_oe, per_in[0]}, 12'h000)
    ext6_val <= 8'hbc;
    ext6_en <= 8'hb0;
    wr(`GPP_OFS_CTRL, 8'h07);
    idle(4);
    `CHK(per_in[2:0], 3'b110)
    rdc(`GPP_OFS_CTRL, 8'h07);
    wr(`GPP_OFS_CTRL, 8'h00);
    idle(4);
    `CHK({p6_oe, p7_oe}, 11'h07f)
    standby <= 1'b0;
    $display("test standby done");
    // a second reset with outputs enabled must clear every direction bit
    i_sys_rst <= 1'b1;
    idle(2);
    i_sys_rst <= 1'b0;
    idle(1);
    `CHK({p6_oe, p7_oe}, 11'h000)
    rdc(`GPP_OFS_P6_DIR, 8'h00);
    rdc(`GPP_OFS_P7_DIR, 8'h00);
    $display("test mid reset done");
    close_out();
  end
endmodule
bind gpp_top gpp_props u_props (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .i_standby(i_standby), .o_p6_pin_out(o_p6_pin_out), .o_p6_pin_oe(o_p6_pin_oe),
  .o_p6_pull_on(o_p6_pull_on), .o_p7_pin_out(o_p7_pin_out), .o_p7_pin_oe(o_p7_pin_oe),
  .o_p7_pull_on(o_p7_pull_on), .i_pulse_gen1_out_a(i_pulse_gen1_out_a),
  .i_pulse_gen1_out_a_oe(i_pulse_gen1_out_a_oe),
  .i_composite_timer1_out_b(i_composite_timer1_out_b),
  .i_composite_timer1_out_b_oe(i_composite_timer1_out_b_oe),
  .i_serial_tx_out(i_serial_tx_out), .i_serial_tx_oe(i_serial_tx_oe),
  .i_reload_timer0_out(i_reload_timer0_out), .i_reload_timer0_out_oe(i_reload_timer0_out_oe));
`default_nettype wire
